// ### fsd_map.vh
// register map, field positions, reset values and constants of the fsk sync detect block
`ifndef FSD_MAP_VH
`define FSD_MAP_VH

// --------------------------------------------------------------------------
// register indexes on the register port
// --------------------------------------------------------------------------
`define FSD_IDX_MOD_CFG      3'h0
`define FSD_IDX_RATE_CFG     3'h1
`define FSD_IDX_RXFEC_CFG    3'h2
`define FSD_IDX_THR_CFG      3'h3
`define FSD_IDX_SYNC_CFG     3'h4
`define FSD_IDX_PRE_LEN_LOW  3'h5

// --------------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------------
`define FSD_RST_MOD_CFG      8'hD6
`define FSD_RST_RATE_CFG     8'h00
`define FSD_RST_RXFEC_CFG    8'h41
`define FSD_RST_THR_CFG      8'h80
`define FSD_RST_SYNC_CFG     8'h18
`define FSD_RST_PRE_LEN_LOW  8'h00

// --------------------------------------------------------------------------
// writable bit masks (others read as zero)
// --------------------------------------------------------------------------
`define FSD_MASK_RATE_CFG    8'hEF
`define FSD_MASK_SYNC_CFG    8'h7F

// --------------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------------
`define FSD_BT_MSB           7
`define FSD_BT_LSB           6
`define FSD_MOD_INDEX_SCALE_MSB        5
`define FSD_MOD_INDEX_SCALE_LSB        4
`define FSD_MOD_INDEX_MSB         3
`define FSD_MOD_INDEX_LSB         1
`define FSD_MOD_ORDER_BIT         0
`define FSD_PLH_MSB          7
`define FSD_PLH_LSB          6
`define FSD_FI_BIT           5
`define FSD_SYMBOL_RATE_SEL_MSB        3
`define FSD_SYMBOL_RATE_SEL_LSB        0
`define FSD_PREAMBLE_RSSI_MODE_BIT         7
`define FSD_RXO_MSB          6
`define FSD_RXO_LSB          5
`define FSD_PREAMBLE_TIMEOUT_BIT        4
`define FSD_MSE_BIT          3
`define FSD_PRI_BIT          2
`define FSD_FEC_SCHEME_BIT         1
`define FSD_FEC_INTERLEAVE_BIT        0
`define FSD_SYNC_DETECT_THRESHOLD_MSB         7
`define FSD_SYNC_DETECT_THRESHOLD_LSB         4
`define FSD_PDT_MSB          3
`define FSD_PDT_LSB          0
`define FSD_SYNC_HARD_QUANT_BIT         6
`define FSD_SYNC_SINGLE_SENSE_BIT        5
`define FSD_RAWR_BIT         4
`define FSD_FT1_MSB          3
`define FSD_FT1_LSB          2
`define FSD_FT0_MSB          1
`define FSD_FT0_LSB          0

// --------------------------------------------------------------------------
// correlator constants
// --------------------------------------------------------------------------
`define FSD_WORD_LEN         16
`define FSD_HIST_DEPTH       32
`define FSD_EST_W            4
`define FSD_EST_POS_MAX      5'h07
`define FSD_EST_NEG_MAX      5'h19
`define FSD_EST_NEG_OVR      4'h8

`endif

// ### fsd_est_hist.v
// shift memory holding the most recent soft frequency estimates
`timescale 1ns/1ps

module fsd_est_hist #(
    parameter DEPTH = 32,
    parameter W     = 4
) (
    // clock and reset
    input  wire                 clk_sys,
    input  wire                 rst_n,
    // write side
    input  wire                 push,
    input  wire                 clear,
    input  wire [W-1:0]         din,
    // read side, slot 0 newest
    output reg  [DEPTH*W-1:0]   hist_q
);

    // shift in newest estimate at slot 0, oldest falls off the top
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hist_q <= {(DEPTH*W){1'b0}};
        end else if (clear) begin
            hist_q <= {(DEPTH*W){1'b0}};
        end else if (push) begin
            hist_q <= {hist_q[DEPTH*W-W-1:0], din};
        end
    end

endmodule // fsd_est_hist

// ### fsd_sync_detect.v
// fsk configuration registers and sync word correlator
//
// Contract
// - soft estimates are integers -7..+7; -8 input is clamped to -7
// - dual sense: two 16-estimate hypotheses against word 0 and word 1
// - correlation threshold is seven times the sync detect threshold field
// - single sense: word 0 on k..k+15 and word 1 on k+16..k+31 both exceed
// - hard quantization maps negative to -7, zero or positive to +7
// - bits 7:6 of modulation config select shaping bandwidth-time, reset 3
// - bits 5:4 scale the modulation index by 7/8, 1, 9/8, 5/4
// - bits 3:1 select modulation index 0.375 to 2.0, reset code 3
// - bit 0 selects two-level or four-level fsk, reset two-level
// - preamble length is 10 bits: two high bits plus low byte register
// - freq_invert inverts the sign of the fsk deviation
// - bits 3:0 select symbol rate 50 to 400 kHz, reset code 0
// - preamble_rssi_mode makes preamble detection use rssi, off at reset
// - receiver override restarts on 6, 12, 18 dB stronger frame; 3 disables
// - preamble_timeout restarts sync after one preamble length without sync
// - mode_switch_enable makes the mode-switch header bit evaluated
// - preamble_invert inverts deviation sign during the preamble only
// - fec_scheme selects non-recursive or recursive systematic code
// - fec_interleave enables code-symbol interleaving, reset on
// - lower preamble detect threshold means a more sensitive detector
// - sync config holds hard quant, single sense, msb first, frame types
// - frame type per word: uncoded std, uncoded raw, coded std, coded raw
// - 32-bit word is word 1 high, word 1 low, word 0 high, word 0 low
// - raw_msb_first orders raw payload octets msb first
`timescale 1ns/1ps
`include "fsd_map.vh"

module fsd_sync_detect (
    // clock and reset
    input  wire         clk_sys,
    input  wire         rst_n,
    // register port
    input  wire [2:0]   reg_addr,
    input  wire         reg_wr,
    input  wire [7:0]   reg_wdata,
    output reg  [7:0]   reg_rdata_q,
    // demodulator estimates
    input  wire         est_valid,
    input  wire [3:0]   est_value,
    input  wire         corr_clear,
    // programmed sync words, bit 0 sent first
    input  wire [15:0]  sync_word0,
    input  wire [15:0]  sync_word1,
    // correlator result
    output reg          sync_found_q,
    output reg          sync_word_sel_q,
    output reg  [1:0]   sync_frame_type_q,
    // modulation configuration
    output wire [1:0]   shaping_bandwidth_time,
    output wire [1:0]   mod_index_scale,
    output wire [2:0]   mod_index,
    output wire         mod_order,
    output reg  [7:0]   mod_index_eff_q,
    // rate and preamble configuration
    output reg  [9:0]   preamble_len_q,
    output wire         freq_invert,
    output wire [3:0]   symbol_rate_sel,
    output reg  [8:0]   symbol_rate_khz_q,
    // receiver and fec configuration
    output wire         preamble_rssi_mode,
    output wire [1:0]   receiver_override,
    output reg          override_enable_q,
    output reg  [4:0]   override_step_db_q,
    output wire         preamble_timeout,
    output wire         mode_switch_enable,
    output wire         preamble_invert,
    output wire         fec_scheme,
    output wire         fec_interleave,
    // thresholds and sync search configuration
    output wire [3:0]   sync_detect_threshold,
    output wire [3:0]   preamble_detect_threshold,
    output wire         sync_hard_quant,
    output wire         sync_single_sense,
    output wire         raw_msb_first,
    output wire [1:0]   frame_type_word0,
    output wire [1:0]   frame_type_word1
);

    // --------------------------------------------------------------------
    // functions
    // --------------------------------------------------------------------

    // signed weighted term of one estimate against one sync bit
    function [4:0] fsd_term;
        input       wbit;
        input [3:0] est;
        input       hard;
        reg   [4:0] v;
        begin
            v = {est[3], est};
            if (est == `FSD_EST_NEG_OVR) begin
                v = `FSD_EST_NEG_MAX;
            end
            if (hard) begin
                v = est[3] ? `FSD_EST_NEG_MAX : `FSD_EST_POS_MAX;
            end
            fsd_term = wbit ? v : (5'h00 - v);
        end
    endfunction

    // correlate 16 history slots starting at base against a word
    function [8:0] fsd_corr;
        input [`FSD_HIST_DEPTH*`FSD_EST_W-1:0] hist;
        input [15:0]                           word;
        input [5:0]                            base;
        input                                  hard;
        integer     n;
        reg   [4:0] t;
        reg   [8:0] acc;
        begin
            acc = 9'h000;
            t   = 5'h00;
            // x(k+n) sits at slot base-n, slot 0 newest
            for (n = 0; n < `FSD_WORD_LEN; n = n + 1) begin
                t   = fsd_term(word[n], hist[(base - n)*`FSD_EST_W +: `FSD_EST_W], hard);
                acc = acc + {{4{t[4]}}, t};
            end
            fsd_corr = acc;
        end
    endfunction

    // --------------------------------------------------------------------
    // configuration registers
    // --------------------------------------------------------------------
    reg  [7:0]  mod_cfg_q;
    reg  [7:0]  rate_cfg_q;
    reg  [7:0]  rxfec_cfg_q;
    reg  [7:0]  thr_cfg_q;
    reg  [7:0]  sync_cfg_q;
    reg  [7:0]  pre_len_low_q;

    // register writes; reserved bits stay zero
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mod_cfg_q     <= `FSD_RST_MOD_CFG;
            rate_cfg_q    <= `FSD_RST_RATE_CFG;
            rxfec_cfg_q   <= `FSD_RST_RXFEC_CFG;
            thr_cfg_q     <= `FSD_RST_THR_CFG;
            sync_cfg_q    <= `FSD_RST_SYNC_CFG;
            pre_len_low_q <= `FSD_RST_PRE_LEN_LOW;
        end else if (reg_wr) begin
            case (reg_addr)
                `FSD_IDX_MOD_CFG:     mod_cfg_q     <= reg_wdata;
                `FSD_IDX_RATE_CFG:    rate_cfg_q    <= reg_wdata & `FSD_MASK_RATE_CFG;
                `FSD_IDX_RXFEC_CFG:   rxfec_cfg_q   <= reg_wdata;
                `FSD_IDX_THR_CFG:     thr_cfg_q     <= reg_wdata;
                `FSD_IDX_SYNC_CFG:    sync_cfg_q    <= reg_wdata & `FSD_MASK_SYNC_CFG;
                `FSD_IDX_PRE_LEN_LOW: pre_len_low_q <= reg_wdata;
                default:              pre_len_low_q <= pre_len_low_q;
            endcase
        end
    end

    // registered read data, unmapped indexes read zero
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= 8'h00;
        end else begin
            case (reg_addr)
                `FSD_IDX_MOD_CFG:     reg_rdata_q <= mod_cfg_q;
                `FSD_IDX_RATE_CFG:    reg_rdata_q <= rate_cfg_q;
                `FSD_IDX_RXFEC_CFG:   reg_rdata_q <= rxfec_cfg_q;
                `FSD_IDX_THR_CFG:     reg_rdata_q <= thr_cfg_q;
                `FSD_IDX_SYNC_CFG:    reg_rdata_q <= sync_cfg_q;
                `FSD_IDX_PRE_LEN_LOW: reg_rdata_q <= pre_len_low_q;
                default:              reg_rdata_q <= 8'h00;
            endcase
        end
    end

    // --------------------------------------------------------------------
    // configuration fields to the baseband
    // --------------------------------------------------------------------

    // modulation fields
    assign shaping_bandwidth_time = mod_cfg_q[`FSD_BT_MSB:`FSD_BT_LSB];
    assign mod_index_scale        = mod_cfg_q[`FSD_MOD_INDEX_SCALE_MSB:`FSD_MOD_INDEX_SCALE_LSB];
    assign mod_index              = mod_cfg_q[`FSD_MOD_INDEX_MSB:`FSD_MOD_INDEX_LSB];
    assign mod_order              = mod_cfg_q[`FSD_MOD_ORDER_BIT];

    // rate and preamble fields
    assign freq_invert            = rate_cfg_q[`FSD_FI_BIT];
    assign symbol_rate_sel        = rate_cfg_q[`FSD_SYMBOL_RATE_SEL_MSB:`FSD_SYMBOL_RATE_SEL_LSB];

    // receiver and fec fields
    assign preamble_rssi_mode     = rxfec_cfg_q[`FSD_PREAMBLE_RSSI_MODE_BIT];
    assign receiver_override      = rxfec_cfg_q[`FSD_RXO_MSB:`FSD_RXO_LSB];
    assign preamble_timeout       = rxfec_cfg_q[`FSD_PREAMBLE_TIMEOUT_BIT];
    assign mode_switch_enable     = rxfec_cfg_q[`FSD_MSE_BIT];
    assign preamble_invert        = rxfec_cfg_q[`FSD_PRI_BIT];
    assign fec_scheme             = rxfec_cfg_q[`FSD_FEC_SCHEME_BIT];
    assign fec_interleave         = rxfec_cfg_q[`FSD_FEC_INTERLEAVE_BIT];

    // thresholds and sync search fields
    assign sync_detect_threshold     = thr_cfg_q[`FSD_SYNC_DETECT_THRESHOLD_MSB:`FSD_SYNC_DETECT_THRESHOLD_LSB];
    assign preamble_detect_threshold = thr_cfg_q[`FSD_PDT_MSB:`FSD_PDT_LSB];
    assign sync_hard_quant           = sync_cfg_q[`FSD_SYNC_HARD_QUANT_BIT];
    assign sync_single_sense         = sync_cfg_q[`FSD_SYNC_SINGLE_SENSE_BIT];
    assign raw_msb_first             = sync_cfg_q[`FSD_RAWR_BIT];
    assign frame_type_word0          = sync_cfg_q[`FSD_FT0_MSB:`FSD_FT0_LSB];
    assign frame_type_word1          = sync_cfg_q[`FSD_FT1_MSB:`FSD_FT1_LSB];

    // --------------------------------------------------------------------
    // derived settings
    // --------------------------------------------------------------------
    reg  [4:0]  mod_index_eighths;
    reg  [3:0]  scale_eighths;
    reg  [8:0]  rate_khz;
    reg  [4:0]  ovr_db;
    wire [8:0]  mod_index_prod;

    // index in eighths and scale in eighths
    always @* begin
        case (mod_index)
            3'h0:    mod_index_eighths = 5'h03;
            3'h1:    mod_index_eighths = 5'h04;
            3'h2:    mod_index_eighths = 5'h06;
            3'h3:    mod_index_eighths = 5'h08;
            3'h4:    mod_index_eighths = 5'h0A;
            3'h5:    mod_index_eighths = 5'h0C;
            3'h6:    mod_index_eighths = 5'h0E;
            default: mod_index_eighths = 5'h10;
        endcase
        case (mod_index_scale)
            2'h0:    scale_eighths = 4'h7;
            2'h1:    scale_eighths = 4'h8;
            2'h2:    scale_eighths = 4'h9;
            default: scale_eighths = 4'hA;
        endcase
    end

    // applied index in 1/64 steps
    assign mod_index_prod = {4'h0, mod_index_eighths} * {5'h00, scale_eighths};

    // symbol rate and override step decode; unused rate codes give zero
    always @* begin
        case (symbol_rate_sel)
            4'h0:    rate_khz = 9'h032;
            4'h1:    rate_khz = 9'h064;
            4'h2:    rate_khz = 9'h096;
            4'h3:    rate_khz = 9'h0C8;
            4'h4:    rate_khz = 9'h12C;
            4'h5:    rate_khz = 9'h190;
            default: rate_khz = 9'h000;
        endcase
        case (receiver_override)
            2'h0:    ovr_db = 5'h06;
            2'h1:    ovr_db = 5'h0C;
            2'h2:    ovr_db = 5'h12;
            default: ovr_db = 5'h00;
        endcase
    end

    // register the derived settings
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mod_index_eff_q    <= 8'h00;
            preamble_len_q     <= 10'h000;
            symbol_rate_khz_q  <= 9'h000;
            override_enable_q  <= 1'b0;
            override_step_db_q <= 5'h00;
        end else begin
            mod_index_eff_q    <= mod_index_prod[7:0];
            preamble_len_q     <= {rate_cfg_q[`FSD_PLH_MSB:`FSD_PLH_LSB],
                                   pre_len_low_q};
            symbol_rate_khz_q  <= rate_khz;
            override_enable_q  <= (receiver_override != 2'h3);
            override_step_db_q <= ovr_db;
        end
    end

    // --------------------------------------------------------------------
    // estimate history
    // --------------------------------------------------------------------
    wire [`FSD_HIST_DEPTH*`FSD_EST_W-1:0] hist;
    reg  [5:0]                            fill_q;
    reg                                   eval_q;

    fsd_est_hist #(
        .DEPTH   (`FSD_HIST_DEPTH),
        .W       (`FSD_EST_W)
    ) u_hist (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .push    (est_valid),
        .clear   (corr_clear),
        .din     (est_value),
        .hist_q  (hist)
    );

    // count stored estimates so no hypothesis looks at empty slots
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fill_q <= 6'h00;
            eval_q <= 1'b0;
        end else begin
            eval_q <= est_valid & ~corr_clear;
            if (corr_clear) begin
                fill_q <= 6'h00;
            end else if (est_valid && fill_q != 6'h20) begin
                fill_q <= fill_q + 6'h01;
            end
        end
    end

    // --------------------------------------------------------------------
    // correlator
    // --------------------------------------------------------------------
    wire [7:0]  thr;
    wire [8:0]  sum_dual0;
    wire [8:0]  sum_dual1;
    wire [8:0]  sum_single0;
    wire [8:0]  sum_single1;
    wire        hit_dual0;
    wire        hit_dual1;
    wire        hit_single;

    // threshold is 7 x field
    assign thr = {1'b0, sync_detect_threshold, 3'h0} - {4'h0, sync_detect_threshold};

    // dual sense: last 16 estimates, slot 15 oldest
    assign sum_dual0 = fsd_corr(hist, sync_word0, 6'h0F, sync_hard_quant);
    assign sum_dual1 = fsd_corr(hist, sync_word1, 6'h0F, sync_hard_quant);

    // single sense: word 0 on older half, word 1 on newer half
    assign sum_single0 = fsd_corr(hist, sync_word0, 6'h1F, sync_hard_quant);
    assign sum_single1 = fsd_corr(hist, sync_word1, 6'h0F, sync_hard_quant);

    // strict greater-than comparisons in signed arithmetic
    assign hit_dual0  = ($signed(sum_dual0) > $signed({1'b0, thr})) && (fill_q >= 6'h10);
    assign hit_dual1  = ($signed(sum_dual1) > $signed({1'b0, thr})) && (fill_q >= 6'h10);
    assign hit_single = ($signed(sum_single0) > $signed({1'b0, thr}))
                        && ($signed(sum_single1) > $signed({1'b0, thr}))
                        && (fill_q == 6'h20);

    // detection pulse with the matching word and its frame type
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_found_q      <= 1'b0;
            sync_word_sel_q   <= 1'b0;
            sync_frame_type_q <= 2'h0;
        end else begin
            sync_found_q <= 1'b0;
            if (eval_q && !corr_clear) begin
                if (sync_single_sense) begin
                    if (hit_single) begin
                        sync_found_q      <= 1'b1;
                        sync_word_sel_q   <= 1'b0;
                        sync_frame_type_q <= frame_type_word0;
                    end
                end else if (hit_dual0) begin
                    sync_found_q      <= 1'b1;
                    sync_word_sel_q   <= 1'b0;
                    sync_frame_type_q <= frame_type_word0;
                end else if (hit_dual1) begin
                    sync_found_q      <= 1'b1;
                    sync_word_sel_q   <= 1'b1;
                    sync_frame_type_q <= frame_type_word1;
                end
            end
        end
    end

endmodule // fsd_sync_detect

// ### fsd_sync_detect_chk.sv
// assertion checker on the ports of the fsk sync detect block
`timescale 1ns/1ps
module fsd_sync_detect_chk (
    // clock and reset
    input wire       clk_sys,
    input wire       rst_n,
    // register port and estimates
    input wire [2:0] reg_addr,
    input wire [7:0] reg_rdata_q,
    input wire       est_valid,
    input wire       corr_clear,
    input wire       sync_found_q,
    // configuration fields
    input wire [1:0] shaping_bandwidth_time,
    input wire [1:0] mod_index_scale,
    input wire [2:0] mod_index,
    input wire       mod_order,
    input wire       preamble_rssi_mode,
    input wire [1:0] receiver_override,
    input wire [4:0] override_step_db_q,
    input wire       preamble_timeout,
    input wire       mode_switch_enable,
    input wire       preamble_invert,
    input wire       fec_scheme,
    input wire       fec_interleave,
    input wire [3:0] sync_detect_threshold,
    input wire [3:0] preamble_detect_threshold,
    input wire       sync_hard_quant,
    input wire       sync_single_sense,
    input wire       raw_msb_first,
    input wire [1:0] frame_type_word0,
    input wire [1:0] frame_type_word1
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------------
    // readback matches the fields as they stood at the address edge; override step decode and one-cycle detect pulse
    // ------------------------------------------------------------------
    sequence s_pulse; sync_found_q ##1 !sync_found_q; endsequence
    property p_mod_rd; reg_addr == 3'h0 |=> reg_rdata_q ==
        $past({shaping_bandwidth_time, mod_index_scale, mod_index, mod_order}); endproperty
    property p_rxfec_rd; reg_addr == 3'h2 |=> reg_rdata_q == $past({preamble_rssi_mode,
        receiver_override, preamble_timeout, mode_switch_enable, preamble_invert,
        fec_scheme, fec_interleave}); endproperty
    property p_thr_rd; reg_addr == 3'h3 |=> reg_rdata_q ==
        $past({sync_detect_threshold, preamble_detect_threshold}); endproperty
    property p_sync_rd; reg_addr == 3'h4 |=> reg_rdata_q == $past({1'b0, sync_hard_quant,
        sync_single_sense, raw_msb_first, frame_type_word1, frame_type_word0}); endproperty
    property p_unmapped; reg_addr[2:1] == 2'b11 |=> reg_rdata_q == 8'h00; endproperty
    property p_step; 1'b1 |=> override_step_db_q == ($past(receiver_override) == 2'h3 ?
        5'h00 : 5'h06 + 5'h06 * $past(receiver_override)); endproperty
    property p_found_cause; sync_found_q |-> $past(est_valid && !corr_clear, 2); endproperty
    property p_found_pulse; sync_found_q |-> s_pulse; endproperty
    a_mod_rd: assert property (p_mod_rd) else $error("modulation readback wrong");
    a_rxfec_rd: assert property (p_rxfec_rd) else $error("receiver readback wrong");
    a_thr_rd: assert property (p_thr_rd) else $error("threshold readback wrong");
    a_sync_rd: assert property (p_sync_rd) else $error("sync config readback wrong");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_step: assert property (p_step) else $error("override step wrong");
    a_found_cause: assert property (p_found_cause) else $error("detect without estimate");
    a_found_pulse: assert property (p_found_pulse) else $error("detect not one cycle");
endmodule // fsd_sync_detect_chk

bind fsd_sync_detect fsd_sync_detect_chk fsd_sync_detect_chk_inst (.clk_sys, .rst_n,
    .reg_addr, .reg_rdata_q, .est_valid, .corr_clear, .sync_found_q, .shaping_bandwidth_time,
    .mod_index_scale, .mod_index, .mod_order, .preamble_rssi_mode, .receiver_override,
    .override_step_db_q, .preamble_timeout, .mode_switch_enable, .preamble_invert,
    .fec_scheme, .fec_interleave, .sync_detect_threshold, .preamble_detect_threshold,
    .sync_hard_quant, .sync_single_sense, .raw_msb_first, .frame_type_word0,
    .frame_type_word1);

// ### test_fsd_sync_detect.sv
// self-checking bench for the fsk sync detect block
`timescale 1ns/1ps
module test_fsd_sync_detect;
    reg          clk_sys = 1'b0;
    reg          rst_n = 1'b0;
    reg  [2:0]   reg_addr = 3'h0;
    reg          reg_wr = 1'b0;
    reg  [7:0]   reg_wdata = 8'h00;
    reg          est_valid = 1'b0;
    reg  [3:0]   est_value = 4'h0;
    reg          corr_clear = 1'b0;
    reg  [15:0]  w0 = 16'hA5C3;
    reg  [15:0]  w1 = 16'h5A3C;
    wire [7:0]   reg_rdata_q;
    wire         found;
    wire         sel;
    wire [1:0]   ftype;
    wire [7:0]   eff;
    wire [9:0]   plen;
    wire [8:0]   khz;
    wire [4:0]   step;
    wire         finv;
    wire         oen;
    integer      n_mismatch = 0;
    integer      comparisons = 0;
    integer      hits = 0;
    integer      i;
    fsd_sync_detect fsd_sync_detect_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .est_valid(est_valid), .est_value(est_value), .corr_clear(corr_clear),
        .sync_word0(w0), .sync_word1(w1), .sync_found_q(found), .sync_word_sel_q(sel),
        .sync_frame_type_q(ftype), .shaping_bandwidth_time(), .mod_index_scale(),
        .mod_index(), .mod_order(), .mod_index_eff_q(eff), .preamble_len_q(plen),
        .freq_invert(finv), .symbol_rate_sel(), .symbol_rate_khz_q(khz), .preamble_rssi_mode(),
        .receiver_override(), .override_enable_q(oen), .override_step_db_q(step),
        .preamble_timeout(), .mode_switch_enable(), .preamble_invert(), .fec_scheme(),
        .fec_interleave(), .sync_detect_threshold(), .preamble_detect_threshold(),
        .sync_hard_quant(), .sync_single_sense(), .raw_msb_first(), .frame_type_word0(),
        .frame_type_word1());
    // ------------------------------------------------------------------
    // clock, detection counter and access tasks
    // ------------------------------------------------------------------
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (found === 1'b1) hits = hits + 1;
    task chk(input [127:0] name, input [31:0] exp, input [31:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] %0s expected %0h seen %0h", name, exp, got);
            end
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(negedge clk_sys) reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(negedge clk_sys) reg_wr = 1'b0;
            @(negedge clk_sys);
        end
    endtask
    task rd(input [2:0] a, input [7:0] e);
        begin
            @(negedge clk_sys) reg_addr = a;
            @(negedge clk_sys) chk("read data", e, reg_rdata_q);
        end
    endtask
    // one 16-estimate word, bit 0 oldest, magnitude m
    task send(input [15:0] w, input [3:0] m);
        integer n;
        begin
            for (n = 0; n < 16; n = n + 1) begin
                @(negedge clk_sys) est_valid = 1'b1;
                est_value = w[n] ? m : 4'h0 - m;
            end
            @(negedge clk_sys) est_valid = 1'b0;
        end
    endtask
    task frame(input [15:0] a, input [15:0] b, input s, input [3:0] m, input [1:0] eh,
               input es, input [1:0] et);
        integer h;
        begin
            @(negedge clk_sys) corr_clear = 1'b1;
            @(negedge clk_sys) corr_clear = 1'b0;
            h = hits;
            send(a, m);
            if (s) send(b, m);
            repeat (3) @(negedge clk_sys);
            chk("detections", eh, hits - h);
            chk("word select", es, sel);
            chk("frame type", et, ftype);
        end
    endtask
    task end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
            if (n_mismatch == 0 && comparisons > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        for (i = 0; i < 8; i = i + 1) rd(i, 64'h0000_0018_8041_00D6 >> (i * 8));
        chk("index", 8'h40, eff);
        chk("rate", 9'h032, khz);
        chk("step", 5'h12, step);
        $display("test reset values done");
        for (i = 0; i < 8; i = i + 1) begin
            wr(i, 8'hFF);
            rd(i, 64'h0000_FF7F_FFFF_EFFF >> (i * 8));
        end
        chk("preamble length", 10'h3FF, plen);
        chk("freq invert", 1'b1, finv);
        for (i = 0; i < 7; i = i + 1) begin
            wr(3'h1, i);
            chk("rate", 72'h190_12C_0C8_096_064_032 >> (i * 12) & 72'hFFF, khz);
        end
        for (i = 0; i < 4; i = i + 1) begin
            wr(3'h2, i << 5);
            chk("step", (i == 3) ? 0 : 6 * (i + 1), step);
            chk("override enable", i != 3, oen);
        end
        wr(3'h0, 8'hFE);
        chk("index", 8'hA0, eff);
        wr(3'h0, 8'h00);
        chk("index", 8'h15, eff);
        $display("test field decode done");
        wr(3'h3, 8'h80);
        wr(3'h4, 8'h0E);
        frame(w0, w0, 1'b0, 4'h4, 2'h1, 1'b0, 2'h2);
        frame(w0, w0, 1'b0, 4'h3, 2'h0, 1'b0, 2'h2);
        wr(3'h3, 8'hF0);
        wr(3'h4, 8'h4E);
        frame(w0, w0, 1'b0, 4'h3, 2'h1, 1'b0, 2'h2);
        wr(3'h3, 8'h80);
        wr(3'h4, 8'h0E);
        frame(w1, w1, 1'b0, 4'h4, 2'h1, 1'b1, 2'h3);
        wr(3'h4, 8'h2E);
        frame(w0, w1, 1'b1, 4'h4, 2'h1, 1'b0, 2'h2);
        frame(w1, w0, 1'b1, 4'h4, 2'h0, 1'b0, 2'h2);
        $display("test correlator done");
        end_of_test;
    end
endmodule // test_fsd_sync_detect
